// [rtl/srs_top.sv]
// Sample request sequencer: lead time, request signal, access gating
// and measured-value status after a failed measurement.
// Assumes the mode, gate inputs and results are synchronous to sys_clk_i.
// Contract
// R1: Mode is read only; gates lead time
// R2: Lead time 0 to 30 min, default 0
// R3: Automatic measurement starts after lead time elapses
// R4: Request active from lead start to duration end
// R5: Duration 0 to 60 min, default 3 min
// R6: Always accessible ignores the access input
// R7: Selected input must be active to start
// R8: Preparation drives input active when sample present
// R9: Second channel has independent access selection
// R10: Keep last value holds last good result
// R11: Status bad zeroes value, refreshes timestamp
// R12: Timers count seconds, restart every cycle
//
// Strobed register access and the register offsets are this design's own decisions.
`timescale 1ns/1ps
module srs_top (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic resetn_i,
  // Register port
  input wire logic [3:0] addr_i,
  input wire logic [15:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [15:0] rdata_o,
  // Operating mode and cycle request
  input wire srs_pkg::srs_mode_e mode_i,
  input wire logic cycle_req_i,
  input wire logic [1:0] chan_req_i,
  // Process access inputs
  input wire logic process_access_gate_first_i,
  input wire logic process_access_gate_second_i,
  // Measuring core
  output logic [1:0] meas_start_o,
  input wire srs_pkg::srs_result_s result_i,
  // Outputs to the process
  output logic sample_request_out_o,
  output logic [15:0] value_o,
  output logic value_bad_o,
  output logic [31:0] stamp_o,
  output logic busy_o
);
  // Whole state of the block
  typedef struct packed {
    srs_pkg::srs_state_e fsm;
    logic [25:0] div;
    logic tick;
    logic [2:0] ctrl;
    logic [11:0] lead;
    logic [11:0] dur;
    logic [1:0] chan;
    logic [1:0] start;
    logic [15:0] value;
    logic bad;
    logic [31:0] secs;
    logic [31:0] stamp;
    logic [15:0] rdata;
  } srs_top_s;
  srs_top_s st;
  srs_top_s next_st;

  // Assertions below all share this clock and reset
  default clocking sva_cb @(posedge sys_clk_i);
  endclocking
  default disable iff (!resetn_i);

  // Timer handshakes
  logic lead_busy;
  logic dur_busy;
  logic cyc_load;
  logic [1:0] gate_ok;
  logic auto_mode;

  // Lead timer restarts at each cycle
  srs_sec_timer u_lead (
    .sys_clk_i(sys_clk_i),
    .resetn_i(resetn_i),
    .load_i(cyc_load),
    .secs_i(st.lead),
    .tick_i(st.tick),
    .busy_o(lead_busy)
  );

  // Duration timer runs beside it from the same start
  srs_sec_timer u_dur (
    .sys_clk_i(sys_clk_i),
    .resetn_i(resetn_i),
    .load_i(cyc_load),
    .secs_i(st.dur),
    .tick_i(st.tick),
    .busy_o(dur_busy)
  );

  // Mode decides whether the lead time is waited for
  assign auto_mode = mode_i == srs_pkg::SRS_AUTO; // see R1
  // Cycle starts only from idle
  assign cyc_load = st.fsm == srs_pkg::SRS_IDLE && cycle_req_i;
  // Each channel gated by its own selection; cleared bit ignores input
  assign gate_ok[0] = !st.ctrl[srs_pkg::CTRL_GATE1] ||
                      process_access_gate_first_i; // see R6 see R7 see R8
  assign gate_ok[1] = !st.ctrl[srs_pkg::CTRL_GATE2] ||
                      process_access_gate_second_i; // see R9

  // Next-state logic
  always_comb begin
    next_st = st;
    next_st.start = 2'h0;
    next_st.rdata = 16'h0000;
    // One-second tick divider, free running
    next_st.tick = 1'b0;
    if (st.div == srs_pkg::TICK_LAST) begin
      next_st.div = 26'h0000000;
      next_st.tick = 1'b1; // see R12
    end else begin
      next_st.div = st.div + 26'h0000001;
    end
    if (st.tick) begin
      next_st.secs = st.secs + 32'h00000001;
    end
    // Register writes, out-of-range times clamp to the limit
    if (wr_i) begin
      case (addr_i)
        srs_pkg::REG_CTRL: next_st.ctrl = wdata_i[2:0];
        srs_pkg::REG_LEAD: begin
          // Upper bits count too, so large words never wrap to small
          next_st.lead = (|wdata_i[15:12] ||
                          wdata_i[11:0] > srs_pkg::LEAD_MAX_S) ?
                         srs_pkg::LEAD_MAX_S : wdata_i[11:0]; // see R2
        end
        srs_pkg::REG_DUR: begin
          next_st.dur = (|wdata_i[15:12] ||
                         wdata_i[11:0] > srs_pkg::DUR_MAX_S) ?
                        srs_pkg::DUR_MAX_S : wdata_i[11:0]; // see R5
        end
        default: ;
      endcase
    end
    // Register reads, unmapped reads return zero
    if (rd_i) begin
      case (addr_i)
        srs_pkg::REG_CTRL: next_st.rdata = {13'h0000, st.ctrl};
        srs_pkg::REG_LEAD: next_st.rdata = {4'h0, st.lead};
        srs_pkg::REG_DUR: next_st.rdata = {4'h0, st.dur};
        srs_pkg::REG_STAT: begin
          next_st.rdata = {11'h000, st.bad, dur_busy, lead_busy,
                           st.fsm};
        end
        srs_pkg::REG_VALUE: next_st.rdata = st.value;
        default: next_st.rdata = 16'h0000;
      endcase
    end
    // Cycle sequencing
    case (st.fsm)
      srs_pkg::SRS_IDLE: begin
        if (cycle_req_i) begin
          next_st.chan = chan_req_i;
          next_st.fsm = srs_pkg::SRS_LEAD;
        end
      end
      srs_pkg::SRS_LEAD: begin
        // Outside automatic the lead time does not hold the start
        if (!lead_busy || !auto_mode) begin // see R3
          // Channels whose selected access input is low are skipped for this cycle
          next_st.start = st.chan & gate_ok; // see R7
          next_st.fsm = (|(st.chan & gate_ok)) ?
                        srs_pkg::SRS_MEAS : srs_pkg::SRS_IDLE;
        end
      end
      srs_pkg::SRS_MEAS: begin
        if (result_i.done) begin
          next_st.fsm = srs_pkg::SRS_IDLE;
          if (!result_i.fail) begin
            next_st.value = result_i.value;
            next_st.bad = 1'b0;
            next_st.stamp = st.secs;
          end else if (st.ctrl[srs_pkg::CTRL_BAD]) begin
            next_st.value = 16'h0000; // see R11
            next_st.bad = 1'b1;
            next_st.stamp = st.secs;
          end
          // Otherwise the last good value and stamp stay; see R10
        end
      end
      default: next_st.fsm = srs_pkg::SRS_IDLE;
    endcase
  end

  // Register the state
  always_ff @(posedge sys_clk_i) begin
    if (!resetn_i) begin
      st <= '0;
      st.fsm <= srs_pkg::SRS_IDLE;
      st.ctrl <= srs_pkg::CTRL_RST;
      st.lead <= srs_pkg::LEAD_RST_S;
      st.dur <= srs_pkg::DUR_RST_S;
    end else begin
      st <= next_st;
    end
  end

  // Request covers lead time and signal duration
  assign sample_request_out_o = st.fsm == srs_pkg::SRS_LEAD ||
                                lead_busy || dur_busy; // see R4
  assign meas_start_o = st.start;
  assign value_o = st.value;
  assign value_bad_o = st.bad;
  assign stamp_o = st.stamp;
  assign rdata_o = st.rdata;
  assign busy_o = st.fsm != srs_pkg::SRS_IDLE;

  // Assertions
  // Mode and timer are taken from the decision cycle, so a mode
  // change just after a start cannot trip the check
  a_lead_hold: assert property ( // see R3
    (|meas_start_o && $past(auto_mode)) |-> !$past(lead_busy))
    else $error("measurement started inside lead time");
  a_req_lead: assert property ( // see R4
    (cycle_req_i && !busy_o) |=> sample_request_out_o)
    else $error("request low at lead start");
  a_req_dur: assert property ( // see R4
    (!dur_busy && !lead_busy && !busy_o) |-> !sample_request_out_o)
    else $error("request high after duration");
  a_gate_first: assert property ( // see R7
    meas_start_o[0] |-> $past(gate_ok[0]))
    else $error("first channel started without access");
  a_gate_second: assert property ( // see R9
    meas_start_o[1] |-> $past(gate_ok[1]))
    else $error("second channel started without access");
  a_keep_last: assert property ( // see R10
    (st.fsm == srs_pkg::SRS_MEAS && result_i.done && result_i.fail &&
     !st.ctrl[srs_pkg::CTRL_BAD]) |=> ($stable(value_o) &&
     $stable(value_bad_o) && $stable(stamp_o)))
    else $error("value changed after failed measurement");
  a_bad_zero: assert property ( // see R11
    (st.fsm == srs_pkg::SRS_MEAS && result_i.done && result_i.fail &&
     st.ctrl[srs_pkg::CTRL_BAD]) |=> (value_o == 16'h0000 && value_bad_o))
    else $error("status bad not applied");
  a_lead_limit: assert property ( // see R2 see R5
    st.lead <= srs_pkg::LEAD_MAX_S && st.dur <= srs_pkg::DUR_MAX_S)
    else $error("time setting out of range");
  a_tick_one: assert property ( // see R12
    st.tick |=> !st.tick)
    else $error("tick longer than one cycle");
  // Main scenarios: a start, a skipped cycle, status bad, held request
  c_start: cover property (|meas_start_o);
  c_skip: cover property (st.fsm == srs_pkg::SRS_LEAD &&
    next_st.fsm == srs_pkg::SRS_IDLE);
  c_bad: cover property (value_bad_o);
  c_held: cover property (!busy_o && sample_request_out_o);
endmodule

// [common/srs_pkg.sv]
// Package for the sample request sequencer: timing, settings, carriers.
// Assumes a 40 MHz system clock; the lead and duration settings are held in seconds.
package srs_pkg;
  // System clock rate and the one-second tick derived from it
  localparam int unsigned CLK_HZ = 40000000;
  localparam int unsigned TICK_S = 1;
  localparam int unsigned TICK_CYCLES = CLK_HZ * TICK_S;
  localparam logic [25:0] TICK_LAST = 26'(TICK_CYCLES - 1);
  // Lead time limits in seconds (0:00 .. 30:00), default 0:00
  localparam logic [11:0] LEAD_MAX_S = 12'h708;
  localparam logic [11:0] LEAD_RST_S = 12'h000;
  // Duration limits in seconds (0:00 .. 60:00), default 3:00
  localparam logic [11:0] DUR_MAX_S = 12'he10;
  localparam logic [11:0] DUR_RST_S = 12'h0b4;
  // Register offsets on the plain register port
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_LEAD = 4'h1;
  localparam logic [3:0] REG_DUR = 4'h2;
  localparam logic [3:0] REG_STAT = 4'h3;
  localparam logic [3:0] REG_VALUE = 4'h4;
  // Control field positions
  localparam int unsigned CTRL_GATE1 = 0;
  localparam int unsigned CTRL_GATE2 = 1;
  localparam int unsigned CTRL_BAD = 2;
  localparam logic [2:0] CTRL_RST = 3'h0;
  // Operating modes, read only for this block
  typedef enum logic [1:0] {
    SRS_MANUAL = 2'b00,
    SRS_AUTO = 2'b01,
    SRS_FIELDBUS = 2'b10
  } srs_mode_e;
  // Cycle states
  typedef enum logic [1:0] {
    SRS_IDLE = 2'b00,
    SRS_LEAD = 2'b01,
    SRS_MEAS = 2'b10
  } srs_state_e;
  // Register port request
  typedef struct packed {
    logic [3:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
  } srs_bus_s;
  // Measurement result from the measuring core
  typedef struct packed {
    logic done;
    logic fail;
    logic [15:0] value;
  } srs_result_s;
endpackage

// [rtl/srs_sec_timer.sv]
// Seconds down-counter, one instance per timed phase.
// Assumes the one-second tick is a one-cycle pulse.
`timescale 1ns/1ps
module srs_sec_timer (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic resetn_i,
  // Control
  input wire logic load_i,
  input wire logic [11:0] secs_i,
  input wire logic tick_i,
  // Status
  output logic busy_o
);
  // Whole state of the counter
  typedef struct packed {
    logic [11:0] cnt;
  } srs_tmr_s;
  srs_tmr_s st;
  srs_tmr_s next_st;

  // Load restarts, each tick takes one second off
  always_comb begin
    next_st = st;
    if (load_i) begin
      next_st.cnt = secs_i; // see R12
    end else if (tick_i && st.cnt != 12'h000) begin
      next_st.cnt = st.cnt - 12'h001;
    end
  end

  // Register the state
  always_ff @(posedge sys_clk_i) begin
    if (!resetn_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // Busy while seconds remain
  assign busy_o = st.cnt != 12'h000;
endmodule

// [test/srs_prep_model.sv]
// Sample preparation unit model: drives the two access inputs.
// Assumes the bench says, per channel, when sample is present.
`timescale 1ns/1ps
module srs_prep_model (
  // Clock
  input wire logic sys_clk_i,
  // Sample presence from the bench
  input wire logic [1:0] avail_i,
  // Access inputs of the analyzer
  output logic gate_first_o,
  output logic gate_second_o
);
  // Registered, as a real relay output would lag by a cycle
  always_ff @(posedge sys_clk_i) begin
    gate_first_o <= avail_i[0];
    gate_second_o <= avail_i[1];
  end
endmodule

// [test/testbench.sv]
// Self-checking bench for the sample request sequencer.
// Assumes runs shorter than one second, so no timer ever expires.
`timescale 1ns/1ps
module testbench;
  // One ordinary case
  typedef struct packed {
    logic [1:0] mode;
    logic [2:0] ctrl;
    logic [1:0] avail;
    logic [1:0] chan;
    logic fail;
    logic [15:0] val;
    logic [1:0] start;
    logic [15:0] exp_val;
    logic exp_bad;
  } srs_row_s;
  logic sys_clk_i, resetn_i, wr_i, rd_i, cycle_req_i, gate1, gate2;
  logic [3:0] addr_i;
  logic [15:0] wdata_i, rdata_o, value_o, d;
  logic [1:0] chan_req_i, meas_start_o, avail, st;
  srs_pkg::srs_mode_e mode_i;
  srs_pkg::srs_result_s result_i;
  logic sample_request_out_o, value_bad_o, busy_o;
  logic [31:0] stamp_o;
  int err_count = 0;
  int checks = 0;
  int cycles = 0;
  srs_row_s rows [8];
  srs_top u_dut (.sys_clk_i(sys_clk_i), .resetn_i(resetn_i),
    .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
    .rdata_o(rdata_o), .mode_i(mode_i), .cycle_req_i(cycle_req_i),
    .chan_req_i(chan_req_i), .process_access_gate_first_i(gate1),
    .process_access_gate_second_i(gate2), .meas_start_o(meas_start_o),
    .result_i(result_i), .sample_request_out_o(sample_request_out_o),
    .value_o(value_o), .value_bad_o(value_bad_o), .stamp_o(stamp_o),
    .busy_o(busy_o));
  srs_prep_model u_prep (.sys_clk_i(sys_clk_i), .avail_i(avail),
    .gate_first_o(gate1), .gate_second_o(gate2));
  // 40 MHz clock
  initial begin
    sys_clk_i = 1'b0;
    forever #12.5 sys_clk_i = ~sys_clk_i;
  end
  // Cut a hang short
  always @(posedge sys_clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      err_count++;
      final_report();
    end
  end
  task final_report;
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task chk(input string n, input logic [31:0] seen, input logic [31:0] e);
    checks++;
    if (seen !== e) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", n, e, seen);
    end
  endtask
  task wr(input logic [3:0] a, input logic [15:0] v);
    @(posedge sys_clk_i);
    addr_i <= a;
    wdata_i <= v;
    wr_i <= 1'b1;
    @(posedge sys_clk_i);
    wr_i <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe
  task rd(input logic [3:0] a, output logic [15:0] v);
    @(posedge sys_clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge sys_clk_i);
    rd_i <= 1'b0;
    #1 v = rdata_o;
  endtask
  task req(input logic [1:0] ch);
    @(posedge sys_clk_i);
    cycle_req_i <= 1'b1;
    chan_req_i <= ch;
    @(posedge sys_clk_i);
    cycle_req_i <= 1'b0;
    #1;
  endtask
  // Start a cycle, note which channels were started
  task cyc(input logic [1:0] ch, output logic [1:0] s);
    req(ch);
    s = 2'h0;
    for (int i = 0; i < 20 && s === 2'h0 && busy_o === 1'b1; i++) begin
      @(posedge sys_clk_i);
      #1 s = meas_start_o;
    end
  endtask
  // Hand back one result, wait for the cycle to close
  task done(input logic f, input logic [15:0] v);
    @(posedge sys_clk_i);
    result_i <= srs_pkg::srs_result_s'({1'b1, f, v});
    @(posedge sys_clk_i);
    result_i <= '0;
    #1;
    for (int i = 0; i < 20 && busy_o !== 1'b0; i++) @(posedge sys_clk_i);
    #1;
  endtask
  initial begin
    // Mode, control, avail, chan, fail, value, start, value, bad
    rows = '{'{2'h0, 3'h0, 2'h0, 2'h1, 1'h0, 16'h1234, 2'h1, 16'h1234, 1'h0},
      '{2'h1, 3'h1, 2'h0, 2'h1, 1'h0, 16'h0abc, 2'h0, 16'h1234, 1'h0},
      '{2'h1, 3'h1, 2'h0, 2'h2, 1'h0, 16'h5678, 2'h2, 16'h5678, 1'h0},
      '{2'h1, 3'h2, 2'h1, 2'h2, 1'h0, 16'h0abc, 2'h0, 16'h5678, 1'h0},
      '{2'h2, 3'h2, 2'h2, 2'h2, 1'h1, 16'h1111, 2'h2, 16'h5678, 1'h0},
      '{2'h1, 3'h4, 2'h0, 2'h1, 1'h1, 16'h2222, 2'h1, 16'h0000, 1'h1},
      '{2'h1, 3'h7, 2'h3, 2'h1, 1'h0, 16'h9abc, 2'h1, 16'h9abc, 1'h0},
      '{2'h1, 3'h3, 2'h1, 2'h3, 1'h0, 16'h0777, 2'h1, 16'h0777, 1'h0}};
    {wr_i, rd_i, cycle_req_i, addr_i, wdata_i, chan_req_i, avail} = '0;
    mode_i = srs_pkg::SRS_AUTO;
    result_i = '0;
    resetn_i = 1'b0;
    repeat (4) @(posedge sys_clk_i);
    resetn_i <= 1'b1;
    #1 chk("request", sample_request_out_o, 1'b0);
    rd(srs_pkg::REG_LEAD, d);
    chk("lead", d, srs_pkg::LEAD_RST_S);
    rd(srs_pkg::REG_DUR, d);
    chk("dur", d, srs_pkg::DUR_RST_S);
    rd(4'hf, d);
    chk("unmapped", d, 16'h0000);
    wr(srs_pkg::REG_LEAD, 16'hffff);
    wr(srs_pkg::REG_DUR, 16'h1001);
    rd(srs_pkg::REG_LEAD, d);
    chk("lead max", d, srs_pkg::LEAD_MAX_S);
    rd(srs_pkg::REG_DUR, d);
    chk("dur max", d, srs_pkg::DUR_MAX_S);
    @(posedge sys_clk_i);
    #1 chk("rdata idle", rdata_o, 16'h0000);
    wr(srs_pkg::REG_LEAD, 16'h0000);
    wr(srs_pkg::REG_DUR, 16'h0000);
    // Ordinary cases
    foreach (rows[i]) begin
      @(posedge sys_clk_i);
      mode_i <= srs_pkg::srs_mode_e'(rows[i].mode);
      avail <= rows[i].avail;
      wr(srs_pkg::REG_CTRL, {13'h0, rows[i].ctrl});
      repeat (2) @(posedge sys_clk_i);
      cyc(rows[i].chan, st);
      chk("start", st, rows[i].start);
      if (st !== 2'h0)
        done(rows[i].fail, rows[i].val);
      chk("value", value_o, rows[i].exp_val);
      chk("bad", value_bad_o, rows[i].exp_bad);
    end
    // Request runs from the start, a second request is refused
    req(2'h1);
    chk("request on", sample_request_out_o, 1'b1);
    @(posedge sys_clk_i);
    #1 chk("start at once", meas_start_o, 2'h1);
    req(2'h1);
    repeat (3) begin
      @(posedge sys_clk_i);
      #1 chk("no restart", meas_start_o, 2'h0);
    end
    done(1'b0, 16'h4321);
    chk("value", value_o, 16'h4321);
    chk("request off", sample_request_out_o, 1'b0);
    chk("busy", busy_o, 1'b0);
    // Manual start ignores a running lead time; request holds on
    wr(srs_pkg::REG_LEAD, 16'h0005);
    wr(srs_pkg::REG_DUR, 16'h0005);
    mode_i <= srs_pkg::SRS_MANUAL;
    cyc(2'h1, st);
    chk("manual start", st, 2'h1);
    done(1'b0, 16'h0555);
    chk("request held", sample_request_out_o, 1'b1);
    rd(srs_pkg::REG_STAT, d);
    chk("status", d, 16'h000c);
    rd(srs_pkg::REG_VALUE, d);
    chk("value reg", d, 16'h0555);
    rd(srs_pkg::REG_CTRL, d);
    chk("ctrl reg", d, 16'h0003);
    chk("stamp", stamp_o, 32'h00000000);
    // Automatic start is held while the lead time runs
    @(posedge sys_clk_i);
    mode_i <= srs_pkg::SRS_AUTO;
    req(2'h1);
    repeat (20) begin
      @(posedge sys_clk_i);
      #1 chk("lead wait", meas_start_o, 2'h0);
    end
    chk("lead busy", busy_o, 1'b1);
    chk("lead request", sample_request_out_o, 1'b1);
    // Reset in mid-cycle returns everything to defaults
    @(posedge sys_clk_i);
    resetn_i <= 1'b0;
    @(posedge sys_clk_i);
    resetn_i <= 1'b1;
    #1 chk("reset request", sample_request_out_o, 1'b0);
    chk("reset busy", busy_o, 1'b0);
    chk("reset value", value_o, 16'h0000);
    rd(srs_pkg::REG_DUR, d);
    chk("reset dur", d, srs_pkg::DUR_RST_S);
    rd(srs_pkg::REG_LEAD, d);
    chk("reset lead", d, srs_pkg::LEAD_RST_S);
    final_report();
  end
endmodule
